// ### bench/pmic_control_register_bank_test.sv
// Self-checking bench of the regulator control bank with a host model on its byte side.
// Assumes the design and host model files are compiled first.
`timescale 1ns/1ps
`include "pmicrb_defs.svh"
module pmic_control_register_bank_test;
   localparam logic [1:0] PART_ID = 2'h2;  // Arbitrary value
   localparam logic [7:0] FUSE_ID = 8'h3c; // Arbitrary value
   localparam int         LIMIT   = 20000;
   // ==========================================================
   // Signals
   logic            clk_i;
   logic            rst_i;
   logic            enable_pin_i;
   logic            evt_reset_i;
   logic      [7:0] stat_top_i;
   logic      [7:0] stat_sw_i;
   logic      [7:0] stat_lin_i;
   logic      [7:0] evt_top_i;
   logic      [7:0] evt_sw_i;
   logic      [7:0] evt_lin_i;
   logic      [1:0] power_good_fault_source_i;
   logic      [8:0] load_current_i;
   wire logic       xfer_start_i;
   wire logic       xfer_write_i;
   wire logic       byte_valid_i;
   wire logic       read_ack_i;
   wire logic [7:0] byte_data_i;
   wire logic [7:0] read_data_o;
   wire logic [7:0] pg_config_o;
   wire logic [5:0] sw0_limits_o;
   wire logic       sw0_on_o;
   wire logic       sw0_discharge_o;
   wire logic       sw0_force_pwm_o;
   wire logic       sw0_multiphase_o;
   wire logic       soft_reset_o;
   wire logic       load_select_o;
   wire logic       irq_o;
   int              fails;
   int              n_tests;
   int              cycles;
   logic      [7:0] rd;
   logic      [7:0] rd2;

   // ==========================================================
   // Instances
   pmicrb_bank #(.PART_IDENTITY(PART_ID), .FUSE_VERSION(FUSE_ID)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .xfer_start_i(xfer_start_i), .xfer_write_i(xfer_write_i),
      .byte_valid_i(byte_valid_i), .byte_data_i(byte_data_i), .read_ack_i(read_ack_i),
      .read_data_o(read_data_o), .enable_pin_i(enable_pin_i), .stat_top_i(stat_top_i),
      .stat_sw_i(stat_sw_i), .stat_lin_i(stat_lin_i), .power_good_fault_source_i(power_good_fault_source_i),
      .load_current_i(load_current_i), .evt_top_i(evt_top_i), .evt_reset_i(evt_reset_i),
      .evt_sw_i(evt_sw_i), .evt_lin_i(evt_lin_i), .sw0_on_o(sw0_on_o),
      .sw0_discharge_o(sw0_discharge_o), .sw0_force_pwm_o(sw0_force_pwm_o),
      .sw0_multiphase_o(sw0_multiphase_o), .sw0_limits_o(sw0_limits_o), .pg_config_o(pg_config_o),
      .soft_reset_o(soft_reset_o), .load_select_o(load_select_o), .irq_o(irq_o));
   pmicrb_host_model i_host (
      .clk_i(clk_i), .xfer_start_o(xfer_start_i), .xfer_write_o(xfer_write_i),
      .byte_valid_o(byte_valid_i), .byte_data_o(byte_data_i), .read_ack_o(read_ack_i),
      .read_data_i(read_data_o));

   // ==========================================================
   // Clock and hang guard
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == LIMIT) begin
         fails = fails + 1;
         end_of_test();
      end
   end

   // ==========================================================
   // Helpers
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read twice around a shifted-out byte; index must not move
   task automatic read_chk(input logic [7:0] idx, input logic [7:0] exp);
      i_host.read_reg(idx, rd, rd2);
      check(rd, exp);
      check(rd2, exp);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   // Reset state, identity and status layout
   task automatic t_reset();
      check({7'h00, sw0_discharge_o}, 8'h01);
      check({7'h00, sw0_on_o}, 8'h00);
      read_chk(`PMICRB_OFS_DEVICE_REVISION, {PART_ID, `PMICRB_DEVICE_REVISION_LOW});
      read_chk(`PMICRB_OFS_FUSE_VER, FUSE_ID);
      read_chk(`PMICRB_OFS_SW0_CTRL_A, `PMICRB_RST_SW0_A);
      read_chk(`PMICRB_OFS_ST_TOP, 8'h9e);
   endtask
   // Writes to read-only and unmapped places are dropped
   task automatic t_readonly();
      i_host.write_regs(8'h00, 16'hffff, 2);
      read_chk(8'h00, {PART_ID, 6'h02});
      read_chk(8'h01, FUSE_ID);
      i_host.write_regs(8'h04, 16'h00a5, 1);
      read_chk(8'h04, 8'h00);
   endtask
   // Two data bytes land in consecutive registers
   task automatic t_autoinc();
      i_host.write_regs(8'h02, 16'h2d18, 2);
      read_chk(8'h02, 8'h18);
      read_chk(8'h03, 8'h2d);
      check({2'b00, sw0_limits_o}, 8'h2d);
   endtask
   // Every combination of multiphase force and mode bit
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         i_host.write_regs(8'h02, {11'h000, m[1:0], 3'b000}, 1);
         repeat (4) @(negedge clk_i);
         check({7'h00, sw0_force_pwm_o}, {7'h00, m[0] | m[1]});
         check({7'h00, sw0_multiphase_o}, {7'h00, m[1]});
      end
   endtask
   // One enable case: control byte, pin level, expected outputs
   task automatic en_case(input logic [7:0] val, input logic pin, input logic on, input logic dis);
      enable_pin_i = pin;
      i_host.write_regs(8'h02, {8'h00, val}, 1);
      repeat (6) @(negedge clk_i);
      check({7'h00, sw0_on_o}, {7'h00, on});
      check({7'h00, sw0_discharge_o}, {7'h00, dis});
   endtask
   // Masked flag is kept but raises nothing; clear by write-one
   task automatic t_mask();
      i_host.write_regs(8'h20, 16'h0001, 1);
      evt_top_i = 8'h01;
      @(negedge clk_i);
      evt_top_i = 8'h00;
      repeat (2) @(negedge clk_i);
      check({7'h00, irq_o}, 8'h00);
      read_chk(8'h19, 8'h01);
      i_host.write_regs(8'h20, 16'h0000, 1);
      repeat (3) @(negedge clk_i);
      check({7'h00, irq_o}, 8'h01);
      i_host.write_regs(8'h19, 16'h0001, 1);
      repeat (3) @(negedge clk_i);
      check({7'h00, irq_o}, 8'h00);
      read_chk(8'h19, 8'h00);
      i_host.write_regs(`PMICRB_OFS_MSK_SW, 16'h0001, 1);
      evt_sw_i = 8'h01;
      @(negedge clk_i);
      evt_sw_i = 8'h00;
      repeat (2) @(negedge clk_i);
      check({7'h00, irq_o}, 8'h00);
      read_chk(`PMICRB_OFS_IRQ_SW, 8'h01);
      i_host.write_regs(`PMICRB_OFS_MSK_SW, 16'h0000, 1);
      check({7'h00, irq_o}, 8'h01);
      i_host.write_regs(`PMICRB_OFS_IRQ_SW, 16'h0001, 1);
      check({7'h00, irq_o}, 8'h00);
   endtask
   // Power-good config, soft reset pulse, load select and status reads
   task automatic t_misc();
      power_good_fault_source_i     = 2'h3;
      load_current_i = 9'h1a5;
      i_host.write_regs(`PMICRB_OFS_PG_CFG_A, 16'hffa5, 2);
      check(pg_config_o, 8'ha5);
      read_chk(`PMICRB_OFS_PG_CFG_B, `PMICRB_PG_B_WMASK);
      read_chk(`PMICRB_OFS_POWER_GOOD_FAULT_SOURCE, 8'h03);
      i_host.write_regs(`PMICRB_OFS_SW_RESET, 16'h0001, 1);
      check({7'h00, soft_reset_o}, 8'h01);
      @(negedge clk_i);
      check({7'h00, soft_reset_o}, 8'h00);
      i_host.write_regs(`PMICRB_OFS_LOAD_SEL, 16'h0001, 1);
      check({7'h00, load_select_o}, 8'h01);
      read_chk(`PMICRB_OFS_LOAD_LO, 8'ha5);
      read_chk(`PMICRB_OFS_LOAD_HI, 8'h01);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      fails          = 0;
      n_tests        = 0;
      cycles         = 0;
      rst_i          = 1'b1;
      enable_pin_i   = 1'b0;
      evt_reset_i    = 1'b0;
      stat_top_i     = 8'hff;
      stat_sw_i      = 8'h00;
      stat_lin_i     = 8'h00;
      evt_top_i      = 8'h00;
      evt_sw_i       = 8'h00;
      evt_lin_i      = 8'h00;
      power_good_fault_source_i     = 2'h0;
      load_current_i = 9'h000;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      t_reset();
      t_readonly();
      t_autoinc();
      t_modes();
      en_case(8'h05, 1'b0, 1'b1, 1'b0);
      en_case(8'h07, 1'b0, 1'b0, 1'b1);
      en_case(8'h07, 1'b1, 1'b1, 1'b0);
      en_case(8'h02, 1'b1, 1'b0, 1'b0);
      t_mask();
      t_misc();
      end_of_test();
   end
endmodule

// ### bench/pmicrb_host_model.sv
// Host model driving the byte side of the serial front end of the regulator bank.
// Assumes a free-running clk_i; every request changes only at falling edges.
`timescale 1ns/1ps
module pmicrb_host_model (
   // Clock
   input  wire logic       clk_i,
   // Requests towards the bank
   output logic            xfer_start_o,
   output logic            xfer_write_o,
   output logic            byte_valid_o,
   output logic      [7:0] byte_data_o,
   output logic            read_ack_o,
   // Answer from the bank
   input  wire logic [7:0] read_data_i
);
   // ==========================================================
   // Idle levels
   initial begin
      xfer_start_o = 1'b0;
      xfer_write_o = 1'b0;
      byte_valid_o = 1'b0;
      byte_data_o  = 8'h00;
      read_ack_o   = 1'b0;
   end

   // Start, index byte, then n data bytes back to back
   task automatic write_regs(input logic [7:0] idx, input logic [15:0] d, input int n);
      @(negedge clk_i);
      xfer_start_o = 1'b1;
      xfer_write_o = 1'b1;
      @(negedge clk_i);
      xfer_start_o = 1'b0;
      byte_valid_o = 1'b1;
      byte_data_o  = idx;
      for (int i = 0; i < n; i++) begin
         @(negedge clk_i);
         byte_data_o = d[8*i +: 8];
      end
      @(negedge clk_i);
      byte_valid_o = 1'b0;
      byte_data_o  = ~byte_data_o;
   endtask

   // Set index, repeated start for read, take a byte, shift it out, take again
   task automatic read_reg(input logic [7:0] idx, output logic [7:0] d, output logic [7:0] d_ack);
      write_regs(idx, 16'h0000, 0);
      xfer_start_o = 1'b1;
      xfer_write_o = 1'b0;
      @(negedge clk_i);
      xfer_start_o = 1'b0;
      repeat (2) @(negedge clk_i);
      d          = read_data_i;
      read_ack_o = 1'b1;
      @(negedge clk_i);
      read_ack_o = 1'b0;
      repeat (2) @(negedge clk_i);
      d_ack = read_data_i;
   endtask
endmodule

// ### rtl/pmicrb_bank.sv
// Control register bank of a dual-switcher, dual-linear regulator device.
// Assumes a serial front end delivering start, index and data bytes on clk_i,
// and analog status levels that are asynchronous to clk_i.
`timescale 1ns/1ps
`include "pmicrb_defs.svh"
module pmicrb_bank #(
   parameter logic [1:0] PART_IDENTITY = 2'h1,  // Arbitrary value
   parameter logic [7:0] FUSE_VERSION  = 8'h5a  // Arbitrary value
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Serial front end transaction bytes
   input  wire logic       xfer_start_i,
   input  wire logic       xfer_write_i,
   input  wire logic       byte_valid_i,
   input  wire logic [7:0] byte_data_i,
   input  wire logic       read_ack_i,
   output logic      [7:0] read_data_o,
   // External enable pin
   input  wire logic       enable_pin_i,
   // Analog status levels
   input  wire logic [7:0] stat_top_i,
   input  wire logic [7:0] stat_sw_i,
   input  wire logic [7:0] stat_lin_i,
   input  wire logic [1:0] power_good_fault_source_i,
   input  wire logic [8:0] load_current_i,
   // Event pulses from the analog monitors
   input  wire logic [7:0] evt_top_i,
   input  wire logic       evt_reset_i,
   input  wire logic [7:0] evt_sw_i,
   input  wire logic [7:0] evt_lin_i,
   // Switcher controls, power-good config, soft reset, load select and interrupt request
   output logic            sw0_on_o,
   output logic            sw0_discharge_o,
   output logic            sw0_force_pwm_o,
   output logic            sw0_multiphase_o,
   output logic      [5:0] sw0_limits_o,
   output logic      [7:0] pg_config_o,
   output logic            soft_reset_o,
   output logic            load_select_o,
   output logic            irq_o
);
   // ==========================================================
   // Serial index engine
   pmicrb_pkg::pmicrb_phase_t phase_r;
   pmicrb_pkg::pmicrb_phase_t phase_nxt;
   logic [7:0]                index_r;
   logic [7:0]                index_nxt;
   logic                      wr_en;
   logic                      rd_en;

   // Function decoding one offset against the index
   function automatic logic hit(input logic [7:0] idx, input logic [7:0] ofs);
      hit = (idx == ofs);
   endfunction

   // First byte after start is the index, later ones are data
   assign wr_en = byte_valid_i && xfer_write_i && (phase_r == pmicrb_pkg::PMICRB_DATA);
   assign rd_en = read_ack_i;

   // Phase sequence
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         pmicrb_pkg::PMICRB_IDLE: begin
            if (xfer_start_i) begin
               phase_nxt = pmicrb_pkg::PMICRB_INDEX;
            end
         end
         pmicrb_pkg::PMICRB_INDEX: begin
            if (xfer_start_i) begin
               phase_nxt = pmicrb_pkg::PMICRB_INDEX;
            end else if (byte_valid_i && xfer_write_i) begin
               phase_nxt = pmicrb_pkg::PMICRB_DATA;
            end
         end
         pmicrb_pkg::PMICRB_DATA: begin
            if (xfer_start_i) begin
               phase_nxt = pmicrb_pkg::PMICRB_INDEX;
            end
         end
         default: begin
            phase_nxt = pmicrb_pkg::PMICRB_IDLE;
         end
      endcase
   end

   // Index loads on first byte, steps after each written byte only
   assign index_nxt = (phase_r == pmicrb_pkg::PMICRB_INDEX && byte_valid_i && xfer_write_i) ? byte_data_i :
                      wr_en ? 8'(index_r + 8'h01) : index_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_r <= pmicrb_pkg::PMICRB_IDLE;
         index_r <= `PMICRB_RST_ZERO;
      end else begin
         phase_r <= phase_nxt;
         index_r <= index_nxt;
      end
   end

   // ==========================================================
   // Synchronisers for pins and analog levels
   logic [35:0] sync1_r;
   logic [35:0] sync2_r;
   logic        pin_en;
   logic [7:0]  st_top;
   logic [7:0]  st_sw;
   logic [7:0]  st_lin;
   logic [1:0]  st_fault;
   logic [8:0]  st_load;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {enable_pin_i, stat_top_i, stat_sw_i, stat_lin_i, power_good_fault_source_i, load_current_i};
         sync2_r <= sync1_r;
      end
   end

   assign {pin_en, st_top, st_sw, st_lin, st_fault, st_load} = sync2_r;

   // ==========================================================
   // Writable registers
   logic [7:0] sw0_a_r;
   logic [7:0] sw0_b_r;
   logic [7:0] pg_a_r;
   logic [7:0] pg_b_r;
   logic       reset_r;
   logic [7:0] msk_top_a_r;
   logic [7:0] msk_top_b_r;
   logic [7:0] msk_sw_r;
   logic [7:0] msk_lin_r;
   logic       load_sel_r;
   logic [7:0] load_lo_r;
   logic       load_hi_r;
   logic       load_lo_rd;

   // Writes; reserved bits hold their reset value
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sw0_a_r     <= `PMICRB_RST_SW0_A;
         sw0_b_r     <= `PMICRB_RST_ZERO;
         pg_a_r      <= `PMICRB_RST_ZERO;
         pg_b_r      <= `PMICRB_RST_ZERO;
         reset_r     <= 1'b0;
         msk_top_a_r <= `PMICRB_RST_ZERO;
         msk_top_b_r <= `PMICRB_RST_ZERO;
         msk_sw_r    <= `PMICRB_RST_ZERO;
         msk_lin_r   <= `PMICRB_RST_ZERO;
         load_sel_r  <= 1'b0;
      end else begin
         reset_r <= 1'b0;
         if (wr_en) begin
            if (hit(index_r, `PMICRB_OFS_SW0_CTRL_A)) begin
               sw0_a_r <= byte_data_i & `PMICRB_SW0_A_WMASK;
            end else if (hit(index_r, `PMICRB_OFS_SW0_CTRL_B)) begin
               sw0_b_r <= byte_data_i & `PMICRB_SW0_B_WMASK;
            end else if (hit(index_r, `PMICRB_OFS_PG_CFG_A)) begin
               pg_a_r <= byte_data_i;
            end else if (hit(index_r, `PMICRB_OFS_PG_CFG_B)) begin
               pg_b_r <= byte_data_i & `PMICRB_PG_B_WMASK;
            end else if (hit(index_r, `PMICRB_OFS_SW_RESET)) begin
               reset_r <= byte_data_i[0];
            end else if (hit(index_r, `PMICRB_OFS_MSK_TOP_A)) begin
               msk_top_a_r <= byte_data_i & `PMICRB_MSK_TOP_A_MASK;
            end else if (hit(index_r, `PMICRB_OFS_MSK_TOP_B)) begin
               msk_top_b_r <= byte_data_i & `PMICRB_IRQ_ONE_MASK;
            end else if (hit(index_r, `PMICRB_OFS_MSK_SW)) begin
               msk_sw_r <= byte_data_i & `PMICRB_MSK_GRP_MASK;
            end else if (hit(index_r, `PMICRB_OFS_MSK_LIN)) begin
               msk_lin_r <= byte_data_i & `PMICRB_MSK_GRP_MASK;
            end else if (hit(index_r, `PMICRB_OFS_LOAD_SEL)) begin
               load_sel_r <= byte_data_i[0];
            end
         end
      end
   end

   // Low load byte read holds the high bit for that one cycle only, and only if the low byte changes
   assign load_lo_rd = rd_en && hit(index_r, `PMICRB_OFS_LOAD_LO);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         load_lo_r <= `PMICRB_RST_ZERO;
         load_hi_r <= 1'b0;
      end else begin
         load_lo_r <= st_load[7:0];
         if (load_lo_rd) begin
            load_hi_r <= load_lo_r == st_load[7:0] ? st_load[8] : load_hi_r;
         end else begin
            load_hi_r <= st_load[8];
         end
      end
   end

   // ==========================================================
   // Interrupt flag groups, write one clears
   logic [7:0] clr_top_a;
   logic [7:0] clr_top_b;
   logic [7:0] clr_sw;
   logic [7:0] clr_lin;
   logic [7:0] flg_top_a;
   logic [7:0] flg_top_b;
   logic [7:0] flg_sw;
   logic [7:0] flg_lin;
   logic [3:0] irq_part;

   assign clr_top_a = (wr_en && hit(index_r, `PMICRB_OFS_IRQ_TOP_A)) ? byte_data_i : 8'h00;
   assign clr_top_b = (wr_en && hit(index_r, `PMICRB_OFS_IRQ_TOP_B)) ? byte_data_i : 8'h00;
   assign clr_sw    = (wr_en && hit(index_r, `PMICRB_OFS_IRQ_SW)) ? byte_data_i : 8'h00;
   assign clr_lin   = (wr_en && hit(index_r, `PMICRB_OFS_IRQ_LIN)) ? byte_data_i : 8'h00;

   pmicrb_irq_group #(.FLAG_MASK(`PMICRB_IRQ_TOP_A_MASK), .GATE_MASK(`PMICRB_MSK_TOP_A_MASK)) u_irq_top_a (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .event_i (evt_top_i),
      .clear_i (clr_top_a),
      .mask_i  (msk_top_a_r),
      .flags_o (flg_top_a),
      .irq_o   (irq_part[0])
   );
   pmicrb_irq_group #(.FLAG_MASK(`PMICRB_IRQ_ONE_MASK), .GATE_MASK(`PMICRB_IRQ_ONE_MASK)) u_irq_top_b (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .event_i ({7'h00, evt_reset_i}),
      .clear_i (clr_top_b),
      .mask_i  (msk_top_b_r),
      .flags_o (flg_top_b),
      .irq_o   (irq_part[1])
   );
   // Flags 0, 2, 4 and 6 share a mask bit position; only the current-limit ones, bits 0 and 4, are gated
   pmicrb_irq_group #(.FLAG_MASK(`PMICRB_IRQ_GRP_MASK), .GATE_MASK(`PMICRB_IRQ_ILIM_GATE)) u_irq_sw (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .event_i (evt_sw_i),
      .clear_i (clr_sw),
      .mask_i  (msk_sw_r),
      .flags_o (flg_sw),
      .irq_o   (irq_part[2])
   );
   pmicrb_irq_group #(.FLAG_MASK(`PMICRB_IRQ_GRP_MASK), .GATE_MASK(`PMICRB_IRQ_ILIM_GATE)) u_irq_lin (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .event_i (evt_lin_i),
      .clear_i (clr_lin),
      .mask_i  (msk_lin_r),
      .flags_o (flg_lin),
      .irq_o   (irq_part[3])
   );

   // The request is the OR of the four group requests
   assign irq_o = |irq_part;

   // ==========================================================
   // Read selection
   logic [7:0] rd_mux;
   logic [7:0] read_data_r;

   assign rd_mux =
      hit(index_r, `PMICRB_OFS_DEVICE_REVISION)   ? {PART_IDENTITY, `PMICRB_DEVICE_REVISION_LOW} :
      hit(index_r, `PMICRB_OFS_FUSE_VER)  ? FUSE_VERSION :
      hit(index_r, `PMICRB_OFS_SW0_CTRL_A) ? sw0_a_r :
      hit(index_r, `PMICRB_OFS_SW0_CTRL_B) ? sw0_b_r :
      hit(index_r, `PMICRB_OFS_PG_CFG_A)  ? pg_a_r :
      hit(index_r, `PMICRB_OFS_PG_CFG_B)  ? pg_b_r :
      hit(index_r, `PMICRB_OFS_POWER_GOOD_FAULT_SOURCE)  ? {6'h00, st_fault} :
      hit(index_r, `PMICRB_OFS_SW_RESET)  ? 8'h00 :
      hit(index_r, `PMICRB_OFS_IRQ_TOP_A) ? flg_top_a :
      hit(index_r, `PMICRB_OFS_IRQ_TOP_B) ? flg_top_b :
      hit(index_r, `PMICRB_OFS_IRQ_SW)    ? flg_sw :
      hit(index_r, `PMICRB_OFS_IRQ_LIN)   ? flg_lin :
      hit(index_r, `PMICRB_OFS_ST_TOP)    ? st_top & `PMICRB_ST_TOP_MASK :
      hit(index_r, `PMICRB_OFS_ST_SW)     ? st_sw & `PMICRB_ST_GRP_MASK :
      hit(index_r, `PMICRB_OFS_ST_LIN)    ? st_lin & `PMICRB_ST_GRP_MASK :
      hit(index_r, `PMICRB_OFS_MSK_TOP_A) ? msk_top_a_r :
      hit(index_r, `PMICRB_OFS_MSK_TOP_B) ? msk_top_b_r :
      hit(index_r, `PMICRB_OFS_MSK_SW)    ? msk_sw_r :
      hit(index_r, `PMICRB_OFS_MSK_LIN)   ? msk_lin_r :
      hit(index_r, `PMICRB_OFS_LOAD_SEL)  ? {7'h00, load_sel_r} :
      hit(index_r, `PMICRB_OFS_LOAD_HI)   ? {7'h00, load_hi_r} :
      hit(index_r, `PMICRB_OFS_LOAD_LO)   ? load_lo_r : 8'h00;

   // Read data registered every cycle, index untouched by reads
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_data_r <= `PMICRB_RST_ZERO;
      end else begin
         read_data_r <= rd_mux;
      end
   end

   // ==========================================================
   // Switcher control outputs
   logic sw0_on_nxt;
   logic sw0_on_r;
   logic sw0_dis_r;

   assign sw0_on_nxt = sw0_a_r[`PMICRB_BIT_TURN_ON] && (!sw0_a_r[`PMICRB_BIT_ON_SOURCE] || pin_en);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sw0_on_r  <= 1'b0;
         sw0_dis_r <= 1'b1;
      end else begin
         sw0_on_r  <= sw0_on_nxt;
         sw0_dis_r <= !sw0_on_nxt && sw0_a_r[`PMICRB_BIT_DISCHARGE];
      end
   end

   assign read_data_o      = read_data_r;
   assign sw0_on_o         = sw0_on_r;
   assign sw0_discharge_o  = sw0_dis_r;
   assign sw0_force_pwm_o  = sw0_a_r[`PMICRB_BIT_FORCE_PWM] | sw0_a_r[`PMICRB_BIT_MULTIPHASE];
   assign sw0_multiphase_o = sw0_a_r[`PMICRB_BIT_MULTIPHASE];
   assign sw0_limits_o     = sw0_b_r[5:0];
   assign pg_config_o      = pg_a_r;
   assign soft_reset_o     = reset_r;
   assign load_select_o    = load_sel_r;

   // ==========================================================
   // Checks
   index_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_en && !xfer_start_i |=> index_r == $past(index_r) + 8'h01)
      else $error("index did not step after write");
   read_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase_r == pmicrb_pkg::PMICRB_DATA) && !byte_valid_i && !xfer_start_i |=> $stable(index_r))
      else $error("index moved without a write");
   ident_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
      index_r == `PMICRB_OFS_DEVICE_REVISION |=> read_data_o[7:6] == PART_IDENTITY)
      else $error("part identity wrong");
   fuse_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
      index_r == `PMICRB_OFS_FUSE_VER |=> read_data_o == FUSE_VERSION)
      else $error("fuse code wrong");
   multiphase_pwm_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sw0_multiphase_o |-> sw0_force_pwm_o)
      else $error("multiphase without forced pulse width");
   mode_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_en && index_r == `PMICRB_OFS_SW0_CTRL_A |=> sw0_force_pwm_o == ($past(byte_data_i[3]) | $past(byte_data_i[4])))
      else $error("mode bit not applied");
   discharge_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sw0_discharge_o |-> !sw0_on_o)
      else $error("discharge while on");
   pin_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sw0_a_r[1] && !pin_en ##1 sw0_a_r[1] |-> !sw0_on_o)
      else $error("pin source ignored");
   turn_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sw0_a_r[0] && !sw0_a_r[1] |=> sw0_on_o)
      else $error("switcher not turned on");
endmodule

// ### rtl/pmicrb_defs.svh
// Register offsets, field positions and reset values of the regulator control bank.
// Assumes inclusion by bare name from design and bench files.
`ifndef PMICRB_DEFS_SVH
`define PMICRB_DEFS_SVH
// ==========================================================
// Offsets
`define PMICRB_OFS_DEVICE_REVISION     8'h00
`define PMICRB_OFS_FUSE_VER    8'h01
`define PMICRB_OFS_SW0_CTRL_A  8'h02
`define PMICRB_OFS_SW0_CTRL_B  8'h03
`define PMICRB_OFS_PG_CFG_A    8'h15
`define PMICRB_OFS_PG_CFG_B    8'h16
`define PMICRB_OFS_POWER_GOOD_FAULT_SOURCE    8'h17
`define PMICRB_OFS_SW_RESET    8'h18
`define PMICRB_OFS_IRQ_TOP_A   8'h19
`define PMICRB_OFS_IRQ_TOP_B   8'h1a
`define PMICRB_OFS_IRQ_SW      8'h1b
`define PMICRB_OFS_IRQ_LIN     8'h1c
`define PMICRB_OFS_ST_TOP      8'h1d
`define PMICRB_OFS_ST_SW       8'h1e
`define PMICRB_OFS_ST_LIN      8'h1f
`define PMICRB_OFS_MSK_TOP_A   8'h20
`define PMICRB_OFS_MSK_TOP_B   8'h21
`define PMICRB_OFS_MSK_SW      8'h22
`define PMICRB_OFS_MSK_LIN     8'h23
`define PMICRB_OFS_LOAD_SEL    8'h24
`define PMICRB_OFS_LOAD_HI     8'h25
`define PMICRB_OFS_LOAD_LO     8'h26
// ==========================================================
// Fields of the first switcher control register and write masks of both
`define PMICRB_BIT_MULTIPHASE  4
`define PMICRB_BIT_FORCE_PWM   3
`define PMICRB_BIT_DISCHARGE   2
`define PMICRB_BIT_ON_SOURCE   1
`define PMICRB_BIT_TURN_ON     0
`define PMICRB_SW0_A_WMASK     8'h1f
`define PMICRB_SW0_B_WMASK     8'h3f
// ==========================================================
// Reset values and read-only patterns
`define PMICRB_RST_SW0_A       8'h04
`define PMICRB_RST_ZERO        8'h00
`define PMICRB_DEVICE_REVISION_LOW     6'h02
`define PMICRB_PG_B_WMASK      8'h07
`define PMICRB_POWER_GOOD_FAULT_SOURCE_MASK   8'h03
`define PMICRB_IRQ_TOP_A_MASK  8'hff
`define PMICRB_IRQ_ONE_MASK    8'h01
`define PMICRB_IRQ_GRP_MASK    8'h77
`define PMICRB_IRQ_ILIM_GATE   8'h11
`define PMICRB_MSK_TOP_A_MASK  8'h95
`define PMICRB_MSK_GRP_MASK    8'hdd
`define PMICRB_ST_TOP_MASK     8'h9e
`define PMICRB_ST_GRP_MASK     8'hdd
`endif

// ### rtl/pmicrb_irq_group.sv
// One interrupt flag register with its mask.
// Assumes event pulses arrive on clk_i.
`timescale 1ns/1ps
`include "pmicrb_defs.svh"
module pmicrb_irq_group #(
   parameter logic [7:0] FLAG_MASK = 8'hff,
   parameter logic [7:0] GATE_MASK = 8'hff
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Events and software clear
   input  wire logic [7:0] event_i,
   input  wire logic [7:0] clear_i,
   input  wire logic [7:0] mask_i,
   // Flags and request
   output logic      [7:0] flags_o,
   output logic            irq_o
);
   logic [7:0] flags_nxt;

   // Set wins over a clear in the same cycle
   assign flags_nxt = ((flags_o & ~clear_i) | event_i) & FLAG_MASK;

   // Flag storage
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_o <= `PMICRB_RST_ZERO;
      end else begin
         flags_o <= flags_nxt;
      end
   end

   // Masked flags stay recorded; only mask bits inside GATE_MASK stop a request
   assign irq_o = |(flags_o & ~(mask_i & GATE_MASK));

   masked_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (event_i[0] && FLAG_MASK[0]) |=> flags_o[0])
      else $error("event flag not recorded");
endmodule

// ### rtl/pmicrb_pkg.sv
// Types shared by the regulator control bank.
// Assumes the defs header is included by users needing numbers.
package pmicrb_pkg;
   // Serial engine phases
   typedef enum logic [1:0] {
      PMICRB_IDLE,
      PMICRB_INDEX,
      PMICRB_DATA
   } pmicrb_phase_t;
endpackage
